// [core/thermal_cap_pkg.sv]
// Constants and carrier types for the sensor capability and configuration block
package thermal_cap_pkg;
    localparam logic [7:0]  PTR_FEATURE_FLAGS  = 8'h00;
    localparam logic [7:0]  PTR_SENSOR_CONFIG  = 8'h01;
    localparam int          REG_W              = 16;
    localparam int          TEMP_W             = 13;
    // Feature flag fields
    localparam int          CAP_SHUTDOWN_BIT   = 7;
    localparam int          CAP_TIMEOUT_BIT    = 6;
    localparam int          CAP_OVERVOLT_BIT   = 5;
    localparam int          CAP_RES_LSB        = 3;
    localparam int          CAP_NEG_BIT        = 2;
    localparam int          CAP_ACC_BIT        = 1;
    localparam int          CAP_ALARM_BIT      = 0;
    localparam logic [1:0]  RESOLUTION_CODE    = 2'h2;
    // Configuration fields
    localparam int          CFG_HYST_LSB       = 9;
    localparam int          CFG_SLEEP_BIT      = 8;
    localparam int          CFG_CRIT_LOCK_BIT  = 7;
    localparam int          CFG_WIN_LOCK_BIT   = 6;
    localparam int          CFG_CLEAR_BIT      = 5;
    localparam int          CFG_STATE_BIT      = 4;
    localparam int          CFG_ALERT_EN_BIT   = 3;
    localparam logic [15:0] CFG_PLAIN_MASK     = 16'h00cf;
    localparam logic [15:0] CFG_RESET          = 16'h0000;
    // Hysteresis in 1/16 degree steps of the temperature word
    localparam logic [TEMP_W:0] HYST_1P5       = 14'h0018;
    localparam logic [TEMP_W:0] HYST_3P0       = 14'h0030;
    localparam logic [TEMP_W:0] HYST_6P0       = 14'h0060;
    // Bus time-out
    localparam int          CLK_HZ             = 10_000_000;
    localparam int          TIMEOUT_MIN_MS     = 25;
    localparam int          TIMEOUT_CYCLES     = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
    localparam int          TIMEOUT_CNT_W      = 18;

    typedef struct packed {
        logic [7:0]       ptr;
        logic             wr;
        logic             rd;
        logic [REG_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic signed [TEMP_W-1:0] temp;
        logic signed [TEMP_W-1:0] upper;
        logic signed [TEMP_W-1:0] lower;
    } sample_t;

    typedef enum logic [1:0] {
        ALERT_RUN,
        ALERT_FROZEN,
        ALERT_RELEASED
    } alert_mode_t;
endpackage

// [core/thermal_cap_config_hysteresis.sv]
// Capability and configuration registers, window flags with hysteresis, alert pin and bus time-out
// Notes on behaviour
// - Pointer 00h holds a read-only 16-bit feature register, fixed apart from bit 7.
// - Feature bits 15:8 always read zero.
// - Behaviour bit 1: alert released in shutdown, stays released until next sample.
// - Behaviour bit 0: alert holds its level in shutdown until next sample.
// - Feature bit 7 follows bus options bit 4.
// - Feature bit 6 reads one; bus time-out between 25 and 35 ms.
// - Time-out also runs in shutdown and during memory accesses.
// - Resolution code bits 4:3 read binary 10.
// - Feature bit 2 reads one, negative temperatures supported.
// - Feature bit 1 gives the accuracy grade fixed at build.
// - Feature bit 0 reads one, alarm capability present.
// - Pointer 01h holds the read/write configuration register, reset zero.
// - Configuration bits 15:11 read zero; host writes zero.
// - Bits 10:9 choose hysteresis: off, 1.5, 3 or 6 degrees.
// - Above flag sets when temperature exceeds the upper limit.
// - Above flag clears only at or below upper limit minus hysteresis.
// - Below flag sets below lower limit and at or below lower limit minus hysteresis.
// - Alert pin uses the same hysteresis decisions as the flags.
// - Either lock bit blocks writes to the hysteresis field.
// - Write-only fields read back as zero.
// - Writes to the feature register are acknowledged but ignored.
`timescale 1ns/100ps
module thermal_cap_config_hysteresis
    import thermal_cap_pkg::*;
#(
    parameter int            TIMEOUT_COUNT = thermal_cap_pkg::TIMEOUT_CYCLES,
    parameter logic          HIGH_ACCURACY = 1'b1
) (
    input  wire logic                              i_clk,
    input  wire logic                              i_reset,
    input  wire thermal_cap_pkg::reg_req_t         i_req,
    output logic                                   o_ack,
    output logic [thermal_cap_pkg::REG_W-1:0]      o_rd_data,
    input  wire logic                              i_alert_freeze_opt,
    input  wire logic                              i_sample_valid,
    input  wire thermal_cap_pkg::sample_t          i_sample,
    input  wire logic                              i_scl_low,
    output logic                                   o_bus_timeout,
    output logic                                   o_above_window,
    output logic                                   o_below_window,
    output logic                                   o_shutdown,
    output logic                                   o_alert_clear,
    output logic                                   o_alert_out,
    output logic                                   o_alert_oe
);
    import thermal_cap_pkg::*;

    logic [REG_W-1:0]         cfg_r;
    logic [REG_W-1:0]         rd_data_r;
    logic                     above_r;
    logic                     below_r;
    logic                     alert_level_r;
    logic                     alert_clear_r;
    alert_mode_t              mode_r;
    alert_mode_t              mode_nxt;
    logic [TIMEOUT_CNT_W-1:0] to_cnt_r;
    logic                     timeout_r;

    // Feature register is constant apart from the alert behaviour bit
    wire logic       shutdown_alert_behaviour;
    wire logic       bus_timeout_flag;
    wire logic       pin_overvoltage_flag;
    wire logic [1:0] resolution_code;
    wire logic       negative_range_flag;
    wire logic       accuracy_grade;
    wire logic       alarm_support_flag;
    assign shutdown_alert_behaviour = i_alert_freeze_opt;
    assign bus_timeout_flag         = 1'b1;
    assign pin_overvoltage_flag     = 1'b1;
    assign resolution_code          = RESOLUTION_CODE;
    assign negative_range_flag      = 1'b1;
    assign accuracy_grade           = HIGH_ACCURACY;
    assign alarm_support_flag       = 1'b1;

    wire logic [REG_W-1:0] feature_word;
    assign feature_word = {8'h00,
                           shutdown_alert_behaviour,
                           bus_timeout_flag,
                           pin_overvoltage_flag,
                           resolution_code,
                           negative_range_flag,
                           accuracy_grade,
                           alarm_support_flag};

    wire logic shutdown_sel;
    wire logic locked;
    wire logic wr_cfg;
    wire logic rd_feature;
    wire logic rd_cfg;
    assign shutdown_sel = cfg_r[CFG_SLEEP_BIT];
    assign locked       = cfg_r[CFG_CRIT_LOCK_BIT] | cfg_r[CFG_WIN_LOCK_BIT];
    assign wr_cfg       = i_req.wr && (i_req.ptr == PTR_SENSOR_CONFIG);
    assign rd_feature   = i_req.ptr == PTR_FEATURE_FLAGS;
    assign rd_cfg       = i_req.ptr == PTR_SENSOR_CONFIG;

    // Every access is acknowledged, including writes to the read-only word
    assign o_ack = i_req.wr | i_req.rd;

    wire logic [1:0] hyst_field;
    wire logic [1:0] hyst_keep;
    assign hyst_field = i_req.wdata[CFG_HYST_LSB +: 2];
    assign hyst_keep  = locked ? cfg_r[CFG_HYST_LSB +: 2] : hyst_field;

    wire logic [REG_W-1:0] cfg_nxt;
    assign cfg_nxt = {5'h00,
                      hyst_keep,
                      i_req.wdata[CFG_SLEEP_BIT],
                      i_req.wdata[7:6],
                      2'b00,
                      i_req.wdata[3:0]};

    // Read view: clear bit is write-only, state bit shows the alert decision
    wire logic [REG_W-1:0] cfg_view;
    assign cfg_view = (cfg_r & {5'h00, 2'b11, 1'b1, CFG_PLAIN_MASK[7:0]})
                    | ({{(REG_W-1){1'b0}}, alert_level_r} << CFG_STATE_BIT);

    wire logic [REG_W-1:0] rd_sel;
    assign rd_sel = rd_feature ? feature_word :
                    rd_cfg     ? cfg_view     : {REG_W{1'b0}};

    // Hysteresis amount, sign-extended arithmetic avoids wrap at range ends
    wire logic signed [TEMP_W:0] hyst;
    assign hyst = (cfg_r[CFG_HYST_LSB +: 2] == 2'b01) ? HYST_1P5 :
                  (cfg_r[CFG_HYST_LSB +: 2] == 2'b10) ? HYST_3P0 :
                  (cfg_r[CFG_HYST_LSB +: 2] == 2'b11) ? HYST_6P0 : '0;

    wire logic signed [TEMP_W:0] t_ext;
    wire logic signed [TEMP_W:0] up_ext;
    wire logic signed [TEMP_W:0] lo_ext;
    assign t_ext  = {i_sample.temp[TEMP_W-1], i_sample.temp};
    assign up_ext = {i_sample.upper[TEMP_W-1], i_sample.upper};
    assign lo_ext = {i_sample.lower[TEMP_W-1], i_sample.lower};

    wire logic above_nxt;
    wire logic below_nxt;
    assign above_nxt = above_r ? !(t_ext <= up_ext - hyst)
                               : (t_ext > up_ext);
    // Clearing wins at the lower limit, so zero hysteresis cannot make the flag toggle
    assign below_nxt = !(t_ext >= lo_ext)
                       && (below_r || (t_ext <= lo_ext - hyst));

    // Samples taken in shutdown are ignored; the converter is off then
    wire logic take_sample;
    assign take_sample = i_sample_valid && !shutdown_sel;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ALERT_RUN: begin
                if (shutdown_sel) begin
                    mode_nxt = i_alert_freeze_opt ? ALERT_RELEASED
                                                  : ALERT_FROZEN;
                end
            end
            ALERT_FROZEN,
            ALERT_RELEASED: begin
                if (take_sample) begin
                    mode_nxt = ALERT_RUN;
                end
            end
            default: mode_nxt = ALERT_RUN;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_data_r     <= '0;
            alert_clear_r <= 1'b0;
        end else begin
            rd_data_r     <= i_req.rd ? rd_sel : rd_data_r;
            alert_clear_r <= wr_cfg && i_req.wdata[CFG_CLEAR_BIT];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            above_r       <= 1'b0;
            below_r       <= 1'b0;
            alert_level_r <= 1'b0;
            mode_r        <= ALERT_RUN;
        end else begin
            mode_r <= mode_nxt;
            if (take_sample) begin
                above_r       <= above_nxt;
                below_r       <= below_nxt;
                alert_level_r <= above_nxt | below_nxt;
            end
        end
    end

    // Time-out counts a held-low clock line regardless of mode or target
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            to_cnt_r  <= '0;
            timeout_r <= 1'b0;
        end else begin
            timeout_r <= 1'b0;
            if (!i_scl_low) begin
                to_cnt_r <= '0;
            end else if (to_cnt_r != TIMEOUT_CNT_W'(TIMEOUT_COUNT)) begin
                to_cnt_r <= to_cnt_r + 1'b1;
                timeout_r <= (to_cnt_r == TIMEOUT_CNT_W'(TIMEOUT_COUNT - 1));
            end
        end
    end

    assign o_rd_data      = rd_data_r;
    assign o_bus_timeout  = timeout_r;
    assign o_above_window = above_r;
    assign o_below_window = below_r;
    assign o_shutdown     = shutdown_sel;
    assign o_alert_clear  = alert_clear_r;
    // Open-drain, active low; released means not driven at all
    assign o_alert_out    = 1'b0;
    assign o_alert_oe     = alert_level_r && cfg_r[CFG_ALERT_EN_BIT] && (mode_r != ALERT_RELEASED);

    a_feature_ro: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.wr && rd_feature |=> $stable(cfg_r))
        else $error("feature write changed configuration");

    a_feature_read: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[15:8] == 8'h00 && o_rd_data[6:0] == {1'b1, 1'b1, 2'b10, 1'b1,
                                   HIGH_ACCURACY, 1'b1})
        else $error("feature word wrong");

    a_cfg_reserved: assert property (@(posedge i_clk) disable iff (i_reset)
        cfg_r[15:11] == 5'h00 && cfg_r[CFG_CLEAR_BIT] == 1'b0)
        else $error("reserved configuration bits set");

    a_hyst_locked: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_cfg && locked |=> cfg_r[10:9] == $past(cfg_r[10:9]))
        else $error("hysteresis changed while locked");

    a_above_set: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && !above_r && t_ext > up_ext |=> o_above_window)
        else $error("above flag not set");

    a_above_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && above_r && t_ext > up_ext - hyst |=> o_above_window)
        else $error("above flag cleared inside hysteresis");

    a_below_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && t_ext >= lo_ext |=> !o_below_window)
        else $error("below flag not cleared");

    a_release_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        mode_r == ALERT_RELEASED && !take_sample |=> !o_alert_oe)
        else $error("alert driven while released");

    a_freeze_level: assert property (@(posedge i_clk) disable iff (i_reset)
        mode_r == ALERT_FROZEN && !take_sample |=> $stable(alert_level_r))
        else $error("frozen alert level moved");

    a_timeout_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
        o_bus_timeout |-> $past(i_scl_low) ##1 !o_bus_timeout)
        else $error("time-out not a single pulse");

    a_feature_upper: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[15:8] == 8'h00)
        else $error("feature upper byte not zero");

    a_feature_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_SHUTDOWN_BIT] == $past(i_alert_freeze_opt))
        else $error("alert behaviour bit not following option");

    a_timeout_cap: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_TIMEOUT_BIT])
        else $error("time-out capability bit clear");

    a_resolution_field: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_RES_LSB +: 2] == RESOLUTION_CODE)
        else $error("resolution code wrong");

    a_negative_range: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_NEG_BIT])
        else $error("negative range bit clear");

    a_accuracy_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_ACC_BIT] == HIGH_ACCURACY)
        else $error("accuracy grade bit wrong");

    a_alarm_support: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_feature |=> o_rd_data[CAP_ALARM_BIT])
        else $error("alarm capability bit clear");

    a_cfg_write: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_cfg |=> cfg_r[CFG_SLEEP_BIT] == $past(i_req.wdata[CFG_SLEEP_BIT]) && cfg_r[3:0] == $past(i_req.wdata[3:0]))
        else $error("configuration write lost");

    a_hyst_write: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_cfg && !locked |=> cfg_r[CFG_HYST_LSB +: 2] == $past(i_req.wdata[CFG_HYST_LSB +: 2]))
        else $error("hysteresis field not written");

    a_hyst_amount: assert property (@(posedge i_clk) disable iff (i_reset)
        cfg_r[CFG_HYST_LSB +: 2] == 2'b10 |-> hyst == HYST_3P0)
        else $error("hysteresis amount wrong");

    a_cfg_read_rsv: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_cfg |=> o_rd_data[15:11] == 5'h00)
        else $error("reserved configuration bits read non-zero");

    a_clear_reads_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.rd && rd_cfg |=> !o_rd_data[CFG_CLEAR_BIT])
        else $error("write-only clear bit read non-zero");

    a_above_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && above_r && t_ext <= up_ext - hyst |=> !o_above_window)
        else $error("above flag not cleared");

    a_below_set: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && t_ext < lo_ext && t_ext <= lo_ext - hyst |=> o_below_window)
        else $error("below flag not set");

    a_direct_above: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && hyst == '0 && !(t_ext > up_ext) |=> !o_above_window)
        else $error("above flag set without hysteresis");

    a_direct_below: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample && hyst == '0 && t_ext < lo_ext |=> o_below_window)
        else $error("below flag clear without hysteresis");

    a_alert_decision: assert property (@(posedge i_clk) disable iff (i_reset)
        take_sample |=> alert_level_r == (o_above_window || o_below_window))
        else $error("alert decision differs from flags");

    a_sleep_ignore: assert property (@(posedge i_clk) disable iff (i_reset)
        shutdown_sel |=> $stable(o_above_window) && $stable(o_below_window))
        else $error("flags moved in shutdown");

    a_release_enter: assert property (@(posedge i_clk) disable iff (i_reset)
        mode_r == ALERT_RUN && shutdown_sel && i_alert_freeze_opt |=> !o_alert_oe)
        else $error("alert not released in shutdown");

    a_ack_every: assert property (@(posedge i_clk) disable iff (i_reset)
        i_req.wr || i_req.rd |-> o_ack)
        else $error("access not acknowledged");

    a_timeout_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_scl_low |=> !o_bus_timeout)
        else $error("time-out without held clock line");
endmodule

// [tb/smbus_host_model.sv]
// Behavioural bus host issuing whole-word register accesses
`timescale 1ns/100ps
module smbus_host_model
    import thermal_cap_pkg::*;
(
    input  wire logic                       i_clk,
    output thermal_cap_pkg::reg_req_t       o_req
);
    import thermal_cap_pkg::*;

    initial o_req = '0;

    // One access per call; lines wander after release so stale data never looks valid
    task automatic access(input logic [7:0] ptr, input logic wr, input logic [15:0] data);
        @(posedge i_clk);
        o_req.ptr   <= ptr;
        o_req.wr    <= wr;
        o_req.rd    <= ~wr;
        o_req.wdata <= {5'h00, data[10:0]};
        @(posedge i_clk);
        o_req.wr    <= 1'b0;
        o_req.rd    <= 1'b0;
        o_req.ptr   <= ~ptr;
        o_req.wdata <= ~data;
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the capability, configuration and window flag block
`timescale 1ns/100ps
module tb;
    import thermal_cap_pkg::*;
    localparam logic signed [12:0] UP = 13'sh00a0;
    localparam logic signed [12:0] LO = 13'sh0000;
    logic              i_clk;
    logic              i_reset;
    logic              i_alert_freeze_opt;
    logic              i_sample_valid;
    logic              i_scl_low;
    reg_req_t          i_req;
    sample_t           i_sample;
    logic              o_ack;
    logic [15:0]       o_rd_data;
    logic              o_bus_timeout;
    logic              o_above_window;
    logic              o_below_window;
    logic              o_shutdown;
    logic              o_alert_clear;
    logic              o_alert_out;
    logic              o_alert_oe;
    logic [15:0]       exp_q[$];
    logic              rd_pend = 1'b0;
    logic              alert_en;
    logic [15:0]       w;
    int                fail_count = 0;
    int                checks_done = 0;
    int                cycles = 0;
    int                hv[4];

    smbus_host_model i_smbus_host_model (.i_clk(i_clk), .o_req(i_req));
    thermal_cap_config_hysteresis #(.TIMEOUT_COUNT(20), .HIGH_ACCURACY(1'b1)) i_thermal_cap_config_hysteresis (
        .i_clk(i_clk), .i_reset(i_reset), .i_req(i_req), .o_ack(o_ack), .o_rd_data(o_rd_data),
        .i_alert_freeze_opt(i_alert_freeze_opt), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
        .i_scl_low(i_scl_low), .o_bus_timeout(o_bus_timeout), .o_above_window(o_above_window),
        .o_below_window(o_below_window), .o_shutdown(o_shutdown), .o_alert_clear(o_alert_clear),
        .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Driver notes the expected word; the monitor below compares it
    task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
        exp_q.push_back(exp);
        i_smbus_host_model.access(ptr, 1'b0, 16'h0000);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
        i_smbus_host_model.access(ptr, 1'b1, data);
    endtask

    // Sample with flag and alert expectations; temp wanders once released
    task automatic smp(input logic signed [12:0] t, input logic a, input logic b);
        @(posedge i_clk);
        i_sample_valid <= 1'b1;
        i_sample       <= '{temp: t, upper: UP, lower: LO};
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        i_sample.temp  <= ~t;
        @(negedge i_clk);
        chk("above_window", {15'h0, a}, {15'h0, o_above_window});
        chk("below_window", {15'h0, b}, {15'h0, o_below_window});
        chk("alert_oe", {15'h0, (a | b) & alert_en}, {15'h0, o_alert_oe});
        chk("alert_out", 16'h0000, {15'h0, o_alert_out});
    endtask

    task automatic tmo();
        int n;
        int at;
        n = 0;
        at = 0;
        @(posedge i_clk);
        i_scl_low <= 1'b1;
        for (int i = 1; i <= 30; i++) begin
            @(negedge i_clk);
            if (o_bus_timeout === 1'b1) begin
                n++;
                at = i;
            end
        end
        @(posedge i_clk);
        i_scl_low <= 1'b0;
        chk("timeout_pulses", 16'd1, 16'(n));
        chk("timeout_cycle", 16'd21, 16'(at));
    endtask

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) rd_pend <= i_req.rd;

    always @(negedge i_clk) begin
        if (rd_pend === 1'b1) begin
            if (exp_q.size() == 0) chk("read_queue", 16'h0001, 16'h0000);
            else chk("rd_data", exp_q.pop_front(), o_rd_data);
        end
    end

    // Hang guard, far above the few hundred cycles the tests take
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        i_reset = 1'b1;
        i_alert_freeze_opt = 1'b1;
        i_sample_valid = 1'b0;
        i_scl_low = 1'b0;
        i_sample = '0;
        alert_en = 1'b1;
        hv = '{0, int'(HYST_1P5), int'(HYST_3P0), int'(HYST_6P0)};
        void'($urandom(32'h97456301));
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(PTR_FEATURE_FLAGS, 16'h00f7);
        rd(PTR_SENSOR_CONFIG, CFG_RESET);
        @(posedge i_clk);
        i_alert_freeze_opt <= 1'b0;
        rd(PTR_FEATURE_FLAGS, 16'h0077);
        fork
            wr(PTR_FEATURE_FLAGS, 16'hffff);
            begin repeat (2) @(negedge i_clk); chk("ack", 16'h0001, {15'h0, o_ack}); end
        join
        rd(PTR_FEATURE_FLAGS, 16'h0077);
        rd(8'h02, 16'h0000);
        $display("test features done");
        for (int k = 0; k < 4; k++) begin
            w = 16'($urandom) & 16'h072f;
            wr(PTR_SENSOR_CONFIG, w);
            @(negedge i_clk);
            chk("alert_clear", {15'h0, w[5]}, {15'h0, o_alert_clear});
            chk("shutdown", {15'h0, w[8]}, {15'h0, o_shutdown});
            rd(PTR_SENSOR_CONFIG, w & 16'h070f);
            wr(PTR_SENSOR_CONFIG, 16'h0000);
        end
        $display("test config done");
        for (int c = 0; c < 4; c++) begin
            wr(PTR_SENSOR_CONFIG, 16'(c << 9) | 16'h0008);
            rd(PTR_SENSOR_CONFIG, 16'(c << 9) | 16'h0008);
            smp(UP + 13'sd1, 1'b1, 1'b0);
            smp(UP, hv[c] != 0, 1'b0);
            smp(UP - 13'(hv[c]), 1'b0, 1'b0);
            smp(LO - 13'sd1, 1'b0, hv[c] == 0);
            smp(LO - 13'(hv[c]) - 13'sd1, 1'b0, 1'b1);
            smp(LO, 1'b0, 1'b0);
        end
        $display("test hysteresis done");
        for (int b = 6; b < 8; b++) begin
            wr(PTR_SENSOR_CONFIG, 16'(1 << b));
            wr(PTR_SENSOR_CONFIG, 16'(1 << b) | 16'h0600);
            rd(PTR_SENSOR_CONFIG, 16'(1 << b));
            wr(PTR_SENSOR_CONFIG, 16'h0000);
        end
        $display("test locks done");
        tmo();
        $display("test timeout done");
        for (int f = 1; f >= 0; f--) begin
            @(posedge i_clk);
            i_alert_freeze_opt <= f[0];
            wr(PTR_SENSOR_CONFIG, 16'h0008);
            smp(UP + 13'sd1, 1'b1, 1'b0);
            wr(PTR_SENSOR_CONFIG, 16'h0108);
            alert_en = ~f[0];
            repeat (2) @(negedge i_clk);
            chk("alert_oe_sleep", {15'h0, ~f[0]}, {15'h0, o_alert_oe});
            smp(LO, 1'b1, 1'b0);
            if (f == 1) tmo();
            wr(PTR_SENSOR_CONFIG, 16'h0008);
            @(negedge i_clk);
            chk("alert_oe_exit", {15'h0, ~f[0]}, {15'h0, o_alert_oe});
            alert_en = 1'b1;
            smp(UP + 13'sd1, 1'b1, 1'b0);
            smp(LO, 1'b0, 1'b0);
            wr(PTR_SENSOR_CONFIG, 16'h0000);
        end
        $display("test shutdown done");
        repeat (3) @(posedge i_clk);
        end_sim();
    end
endmodule
